// file: bench/dtfc_switch_model.sv
// Momentary contact model for one toggle input
// Assumes press_i is a level from the bench, high while pressed
`timescale 1ns/100ps
`default_nettype none
module dtfc_switch_model #(
  parameter int BOUNCE = 3
) (
  input  wire logic clock_i,
  input  wire logic press_i,
  output logic      toggle_n_o
);
  logic last = 1'b0;
  int   cnt  = 0;
  assign toggle_n_o = (cnt > 0) ? cnt[0] : ~last;
  always @(posedge clock_i)
  begin
    last <= press_i;
    if (press_i != last)
      cnt <= BOUNCE;
    else if (cnt > 0)
      cnt <= cnt - 1;
  end
endmodule // dtfc_switch_model
`default_nettype wire

// file: bench/testbench.sv
// Self-checking bench for the toggle fade controller
// Assumes a short debounce count and one contact model per channel
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam int DB = 20;
  typedef struct packed {logic ch; logic [19:0] ohm; logic [1:0] on; logic [9:0] l0, l1;} dtfc_row_s;
  localparam dtfc_row_s ROWS [4] = '{'{1'h0, 20'h00000, 2'h1, 10'h3E8, 10'h000},
    '{1'h1, 20'h00000, 2'h3, 10'h3E8, 10'h3E8}, '{1'h0, 20'h0003F, 2'h2, 10'h000, 10'h3E8},
    '{1'h1, 20'h0003F, 2'h0, 10'h000, 10'h000}};
  logic        clock_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        enable_i = 1'b1;
  logic [1:0]  press = 2'h0;
  logic [19:0] ohm = 20'h00000;
  wire  [1:0]  tog_n;
  logic [9:0]  lvl0, lvl1, prev, held;
  logic [1:0]  on;
  int          error_cnt = 0, checked = 0, cyc = 0, steps = 0, ramp = 0;
  always #20 clock_i = ~clock_i;
  dtfc_switch_model sw0 (.clock_i(clock_i), .press_i(press[0]), .toggle_n_o(tog_n[0]));
  dtfc_switch_model sw1 (.clock_i(clock_i), .press_i(press[1]), .toggle_n_o(tog_n[1]));
  dtfc_top #(.DEBOUNCE_CYC(DB)) uut (.clock_i(clock_i), .rst_i(rst_i), .enable_i(enable_i),
    .channel_toggle_input_n_i(tog_n), .fade_time_program_pin_i(ohm),
    .channel_current_output0_o(lvl0), .channel_current_output1_o(lvl1), .channel_on_o(on));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [9:0] got, input logic [9:0] exp);
    checked++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %0d seen %0d", nm, exp, got);
      error_cnt++;
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic hit(input int ch, input int hold);
    @(posedge clock_i);
    press[ch] <= 1'b1;
    repeat (hold) @(posedge clock_i);
    press[ch] <= 1'b0;
    repeat (2 * DB) @(posedge clock_i);
  endtask
  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    prev <= lvl0;
    if (lvl0 !== prev)
      steps <= steps + 1;
    if (lvl0 > 10'h000 && lvl0 < 10'h3E8)
      ramp <= ramp + 1;
    if (cyc == 60000)
    begin
      error_cnt++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge clock_i);
    rst_i <= 1'b0;
    @(negedge clock_i);
    chk("on after reset", {8'h00, on}, 10'h000);
    chk("level0 after reset", lvl0, 10'h000);
    @(posedge clock_i);
    foreach (ROWS[i])
    begin
      ohm <= ROWS[i].ohm;
      hit(ROWS[i].ch, 2 * DB);
      repeat (4200) @(posedge clock_i);
      chk("row on", {8'h00, on}, {8'h00, ROWS[i].on});
      chk("row level0", lvl0, ROWS[i].l0);
      chk("row level1", lvl1, ROWS[i].l1);
    end
    $display("table rows done");
    ohm <= 20'h00000;
    hit(0, DB / 2);
    hit(0, DB / 2);
    repeat (100) @(posedge clock_i);
    chk("glitch ignored", {8'h00, on}, 10'h000);
    $display("glitch test done");
    for (int j = 0; j < 2; j++)
    begin
      press <= 2'h3;
      repeat (2 * DB) @(posedge clock_i);
      press <= 2'h0;
      repeat (2000) @(posedge clock_i);
      chk("paired on", {8'h00, on}, j ? 10'h000 : 10'h003);
      chk("paired level0", lvl0, j ? 10'h000 : 10'h3E8);
      chk("paired level1", lvl1, j ? 10'h000 : 10'h3E8);
    end
    $display("paired test done");
    for (int k = 0; k < 2; k++)
    begin
      ohm <= k ? 20'h0003F : 20'h00000;
      @(negedge clock_i);
      steps = 0;
      ramp = 0;
      hit(0, 2 * DB);
      repeat (4200) @(posedge clock_i);
      chk("ramp steps", steps[9:0], 10'd62);
      chk("ramp length", {9'h000, (ramp >= (k ? 3781 : 1707)) && (ramp <= (k ? 3783 : 1709))},
          10'h001);
      hit(0, 2 * DB);
      repeat (4200) @(posedge clock_i);
    end
    $display("ramp tests done");
    hit(0, 2 * DB);
    repeat (4200) @(posedge clock_i);
    hit(0, 2 * DB);
    repeat (1000) @(posedge clock_i);
    chk("mid ramp", {9'h000, lvl0 > 10'h000 && lvl0 < 10'h3E8}, 10'h001);
    enable_i <= 1'b0;
    @(posedge clock_i);
    held = lvl0;
    repeat (200) @(posedge clock_i);
    chk("frozen level", lvl0, held);
    enable_i <= 1'b1;
    hit(0, 2 * DB);
    repeat (4200) @(posedge clock_i);
    chk("reversed on", {8'h00, on}, 10'h001);
    chk("reversed level", lvl0, 10'h3E8);
    rst_i <= 1'b1;
    @(negedge clock_i);
    chk("level in reset", lvl0, 10'h000);
    chk("on in reset", {8'h00, on}, 10'h000);
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    @(negedge clock_i);
    chk("on after release", {8'h00, on}, 10'h000);
    chk("level1 after release", lvl1, 10'h000);
    $display("reverse and reset tests done");
    conclude();
  end
endmodule // testbench
`default_nettype wire

// file: hw/dtfc_pkg.sv
// Constants for the dual channel toggle fade controller
// Assumes a 25 MHz core clock
package dtfc_pkg;
  localparam int          CLK_HZ         = 25000000;
  localparam int          DEBOUNCE_MS    = 37;
  localparam int          DEBOUNCE_CYC   = DEBOUNCE_MS * (CLK_HZ / 1000);
  localparam int          STEPS          = 63;
  localparam int          LAST_IDX       = STEPS - 1;
  localparam int          LEVEL_W        = 10;
  localparam int          FADE_W         = 20;
  localparam int          NS_PER_OHM_X10 = 25;
  localparam int          INSTANT_US     = 73;
  localparam int          INSTANT_CYC    = INSTANT_US * (CLK_HZ / 1000000);
  localparam int          INSTANT_STEP   = INSTANT_CYC / STEPS;
  localparam logic [LEVEL_W-1:0] LEVEL_OFF = 10'h000;
  localparam logic [5:0]  IDX_ZERO       = 6'h00;
  localparam logic [5:0]  IDX_LAST       = 6'h3E;
  typedef enum logic [1:0] {DTFC_OFF, DTFC_UP, DTFC_ON, DTFC_DOWN} dtfc_state_e;
endpackage

// file: hw/dtfc_top.sv
// Contract
// - After reset both channels sit off with zero level.
// - Qualified low-going press switches an off channel on.
// - Turning on ramps level from zero to full over fade time.
// - Press while on ramps level down to zero, ending off.
// - Presses during a ramp reverse it from the present level.
// - Each toggle input debounced for nominally 37 ms.
// - Debounce applies equally to press and release.
// - Each ramp passes 63 gamma corrected levels.
// - One shared fade setting serves both channels and directions.
// - Fade time is 2.5 us per ohm of program value.
// - Zero fade setting completes a transition in about 73 us.
// - Zero fade setting keeps full debounce on both inputs.
// - Each channel has its own input and state.
// - Toggle input synchronizer resets to inactive high.
// - Debounce time lies between 25 and 50 ms.
// - Levels follow fixed gamma table from 0 to 1000 thousandths.
////////////////////////////////////////////////////////////////////////
// Toggle, debounce and gamma fade logic for two channels
// Assumes toggle inputs are asynchronous pins, fade setting static
`timescale 1ns/100ps
`default_nettype none
module dtfc_top #(
  parameter int DEBOUNCE_CYC = dtfc_pkg::DEBOUNCE_CYC
) (
  input  wire logic                          clock_i,
  input  wire logic                          rst_i,
  input  wire logic                          enable_i,
  input  wire logic [1:0]                    channel_toggle_input_n_i,
  input  wire logic [dtfc_pkg::FADE_W-1:0]   fade_time_program_pin_i,
  output logic [dtfc_pkg::LEVEL_W-1:0]       channel_current_output0_o,
  output logic [dtfc_pkg::LEVEL_W-1:0]       channel_current_output1_o,
  output logic [1:0]                         channel_on_o
);
  ////////////////////////////////////////////////////////////////////
  // Gamma levels in thousandths of full
  localparam logic [9:0] GAMMA [0:62] = '{
    10'h000,
    10'h002,
    10'h004,
    10'h006,
    10'h008,
    10'h00A,
    10'h00C,
    10'h010,
    10'h014,
    10'h018,
    10'h01C,
    10'h020,
    10'h024,
    10'h02A,
    10'h030,
    10'h036,
    10'h03C,
    10'h042,
    10'h048,
    10'h050,
    10'h058,
    10'h060,
    10'h068,
    10'h070,
    10'h078,
    10'h082,
    10'h08C,
    10'h096,
    10'h0A0,
    10'h0AA,
    10'h0B4,
    10'h0C2,
    10'h0D0,
    10'h0DE,
    10'h0EC,
    10'h0FA,
    10'h108,
    10'h11A,
    10'h12C,
    10'h13E,
    10'h150,
    10'h162,
    10'h174,
    10'h18A,
    10'h1A0,
    10'h1B6,
    10'h1CC,
    10'h1E2,
    10'h1F8,
    10'h216,
    10'h234,
    10'h252,
    10'h270,
    10'h28E,
    10'h2AC,
    10'h2D2,
    10'h2F8,
    10'h31E,
    10'h344,
    10'h36A,
    10'h392,
    10'h3BC,
    10'h3E8
  };

  ////////////////////////////////////////////////////////////////////
  // Shared step timer
  // fade scaling: cycles per step = ohm*2.5us*25MHz/63
  logic [31:0] step_len;
  logic [31:0] step_cnt;
  wire  logic [39:0] fade_cyc;
  wire  logic        step_tick;
  assign fade_cyc = 40'(fade_time_program_pin_i) * 40'h0000000271 / 40'h000000000A;
  // instant mode when setting is zero
  assign step_len = (fade_time_program_pin_i == '0) ? 32'(dtfc_pkg::INSTANT_STEP)
                  : 32'(fade_cyc / 40'(dtfc_pkg::STEPS));
  assign step_tick = (step_cnt + 32'd1 >= step_len);

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      step_cnt <= 32'h00000000;
    else if (enable_i)
      step_cnt <= step_tick ? 32'h00000000 : step_cnt + 32'd1;
  end

  ////////////////////////////////////////////////////////////////////
  // Per channel logic
  logic [1:0]  s1, s2, s3, stable;
  logic [31:0] db_cnt [0:1];
  logic [5:0]  idx [0:1];
  dtfc_pkg::dtfc_state_e st [0:1];
  logic [9:0]  lvl [0:1];
  wire  logic [1:0] press;
  wire  logic [1:0] settled;

  for (genvar c = 0; c < 2; c++)
  begin : g_ch
    assign settled[c] = (db_cnt[c] + 32'd1 >= 32'(DEBOUNCE_CYC));
    // qualified falling edge is a press
    assign press[c] = settled[c] && s3[c] == s2[c] && stable[c] && !s2[c];
    wire logic [9:0] table_lvl;
    assign table_lvl = (idx[c] > dtfc_pkg::IDX_LAST) ? GAMMA[dtfc_pkg::LAST_IDX] : GAMMA[idx[c]];

    always_ff @(posedge clock_i or posedge rst_i)
    begin
      if (rst_i)
      begin
        s1[c]     <= 1'b1;
        s2[c]     <= 1'b1;
        s3[c]     <= 1'b1;
        stable[c] <= 1'b1;
        db_cnt[c] <= 32'h00000000;
      end
      else if (enable_i)
      begin
        s1[c] <= channel_toggle_input_n_i[c];
        s2[c] <= s1[c];
        s3[c] <= s2[c];
        if (s3[c] != s2[c] || s2[c] == stable[c])
          db_cnt[c] <= 32'h00000000;
        else if (settled[c])
        begin
          stable[c] <= s2[c];
          db_cnt[c] <= 32'h00000000;
        end
        else
          db_cnt[c] <= db_cnt[c] + 32'd1;
      end
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
      if (rst_i)
      begin
        st[c]  <= dtfc_pkg::DTFC_OFF;
        idx[c] <= 6'h00;
        lvl[c] <= 10'h000;
      end
      else if (enable_i)
      begin
        lvl[c] <= table_lvl;
        case (st[c])
          dtfc_pkg::DTFC_OFF:  if (press[c]) st[c] <= dtfc_pkg::DTFC_UP;
          dtfc_pkg::DTFC_ON:   if (press[c]) st[c] <= dtfc_pkg::DTFC_DOWN;
          dtfc_pkg::DTFC_UP:
            if (press[c])
              st[c] <= dtfc_pkg::DTFC_DOWN;
            else if (step_tick)
            begin
              // advance one entry, hold at end
              if (idx[c] == dtfc_pkg::IDX_LAST)
                st[c] <= dtfc_pkg::DTFC_ON;
              else
                idx[c] <= idx[c] + 6'h01;
            end
          dtfc_pkg::DTFC_DOWN:
            if (press[c])
              st[c] <= dtfc_pkg::DTFC_UP;
            else if (step_tick)
            begin
              if (idx[c] == dtfc_pkg::IDX_ZERO)
                st[c] <= dtfc_pkg::DTFC_OFF;
              else
                idx[c] <= idx[c] - 6'h01;
            end
          default: st[c] <= dtfc_pkg::DTFC_OFF;
        endcase
      end
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
      if (rst_i)
        channel_on_o[c] <= 1'b0;
      else if (enable_i)
        channel_on_o[c] <= (st[c] == dtfc_pkg::DTFC_UP) || (st[c] == dtfc_pkg::DTFC_ON);
    end

    off_zero_a: assert property (@(posedge clock_i) disable iff (rst_i)
      st[c] == dtfc_pkg::DTFC_OFF && $past(st[c]) == dtfc_pkg::DTFC_OFF && enable_i
      |=> lvl[c] == 10'h000)
      else $error("off channel has level");
    down_step_a: assert property (@(posedge clock_i) disable iff (rst_i)
      st[c] == dtfc_pkg::DTFC_DOWN && !press[c] && step_tick && enable_i && idx[c] != 6'h00
      |=> idx[c] == $past(idx[c]) - 6'h01)
      else $error("ramp down step wrong");
    up_step_a: assert property (@(posedge clock_i) disable iff (rst_i)
      st[c] == dtfc_pkg::DTFC_UP && !press[c] && step_tick && enable_i && idx[c] != 6'h3E
      |=> idx[c] == $past(idx[c]) + 6'h01)
      else $error("ramp up step wrong");
    press_rev_a: assert property (@(posedge clock_i) disable iff (rst_i)
      st[c] == dtfc_pkg::DTFC_UP && press[c] && enable_i |=> st[c] == dtfc_pkg::DTFC_DOWN)
      else $error("ramp not reversed");
    off_on_a: assert property (@(posedge clock_i) disable iff (rst_i)
      st[c] == dtfc_pkg::DTFC_OFF && press[c] && enable_i ##1 enable_i |=> channel_on_o[c])
      else $error("press did not switch on");
    db_restart_a: assert property (@(posedge clock_i) disable iff (rst_i)
      enable_i && s3[c] != s2[c] |=> db_cnt[c] == 32'h00000000)
      else $error("debounce not restarted");
    // stable level follows only after settling
    db_hold_a: assert property (@(posedge clock_i) disable iff (rst_i)
      enable_i && !settled[c] |=> stable[c] == $past(stable[c]))
      else $error("input accepted too early");
    full_on_a: assert property (@(posedge clock_i) disable iff (rst_i)
      enable_i && st[c] == dtfc_pkg::DTFC_ON
      |=> lvl[c] == 10'h3E8)
      else $error("on channel not at full level");
    off_hold_a: assert property (@(posedge clock_i) disable iff (rst_i)
      enable_i && st[c] == dtfc_pkg::DTFC_OFF && !press[c]
      |=> st[c] == dtfc_pkg::DTFC_OFF)
      else $error("channel left off without press");
    up_hold_a: assert property (@(posedge clock_i) disable iff (rst_i)
      enable_i && st[c] == dtfc_pkg::DTFC_UP && !step_tick
      |=> idx[c] == $past(idx[c]))
      else $error("up index moved between steps");
    down_hold_a: assert property (@(posedge clock_i) disable iff (rst_i)
      enable_i && st[c] == dtfc_pkg::DTFC_DOWN && !step_tick
      |=> idx[c] == $past(idx[c]))
      else $error("down index moved between steps");
  end

  // level always a table entry at most full
  lvl_max_a: assert property (@(posedge clock_i) disable iff (rst_i)
    lvl[0] <= 10'd1000 && lvl[1] <= 10'd1000)
    else $error("level above full");

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      channel_current_output0_o <= 10'h000;
      channel_current_output1_o <= 10'h000;
    end
    else if (enable_i)
    begin
      channel_current_output0_o <= lvl[0];
      channel_current_output1_o <= lvl[1];
    end
  end
endmodule // dtfc_top
`default_nettype wire
